/* File: include/fpd_regs.vh */
// Register map, field positions, reset values and timing counts of the FIFO packet data handler.
`ifndef FPD_REGS_VH
`define FPD_REGS_VH
// ----------------------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------------------
`define FPD_A_DATA_PATH_MODE 12'h000
`define FPD_A_FIFO_CONFIG 12'h004
`define FPD_A_IRQ_SELECT 12'h008
`define FPD_A_FILL_START 12'h00c
`define FPD_A_SYNC_CONFIG 12'h010
`define FPD_A_SYNC_B3 12'h014
`define FPD_A_SYNC_B2 12'h018
`define FPD_A_SYNC_B1 12'h01c
`define FPD_A_SYNC_B0 12'h020
`define FPD_A_PACKET_CTRL 12'h024
`define FPD_A_PAYLOAD_LEN 12'h028
`define FPD_A_FIFO_DATA 12'h02c
`define FPD_A_STATUS 12'h030
`define FPD_A_CHIP_MODE 12'h034
// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define FPD_B_MODE_LOW 0
`define FPD_B_MODE_HIGH 1
`define FPD_B_THR_HI 5
`define FPD_B_DEPTH_LO 6
`define FPD_B_LINE1_TX 0
`define FPD_B_RX1_LO 2
`define FPD_B_RX0_LO 4
`define FPD_B_START_SEL 4
`define FPD_B_FILL_CTRL 6
`define FPD_B_FILL_METHOD 7
`define FPD_B_SYNC_EN 7
`define FPD_B_SYNC_SIZE_LO 3
`define FPD_B_SYNC_TOL_LO 1
`define FPD_B_LEN_FORMAT 7
`define FPD_B_CRC_EN 3
// ----------------------------------------------------------------------------
// Reset values and encodings
// ----------------------------------------------------------------------------
`define FPD_RST_BYTE 8'h00
`define FPD_RST_THRESHOLD 8'h0f
`define FPD_RST_PREAMBLE_BYTES 8'h03
`define FPD_SEL_RX0_EMPTY 2'h2
`define FPD_SEL_RX0_SYNC 2'h3
`define FPD_SEL_RX1_FULL 2'h1
`define FPD_SEL_RX1_THR 2'h3
`define FPD_CHIP_STANDBY 2'h0
`define FPD_CHIP_TX 2'h1
`define FPD_CHIP_RX 2'h2
`define FPD_PREAMBLE_BYTE 8'haa
`define FPD_CRC_INIT 16'h1d0f
`define FPD_CRC_POLY 16'h1021
`define FPD_BITS_PER_BYTE 4'h8
`define FPD_BUS_ERR_ADDR 32'hdead_0000
`endif

/* File: rtl/fpd_handler.v */
// FIFO and packet data handler between an APB host port and a bit-serial modem path.
`timescale 1ns/1ps
`include "fpd_regs.vh"
// What this block does
// - Start-select one: send once FIFO holds a byte.
// - Line-one select one: line b shows transmit complete.
// - Line-zero field 10: line a shows empty.
// - Line-one field 11: line b shows threshold.
// - Threshold only after sync, or with fill method selected.
// - Leaving receive drops partial byte, keeps FIFO.
// - Packet mode adds preamble, sync, CRC itself.
// - Packet mode FIFO usable in standby.
// - Packet mode forces bit sync, sync detection.
// - Packet control bit 7 selects length format.
// - Payload length is not capped at the selected FIFO depth.
// - Fixed length field counts address plus message.
// - Fixed payload holds at least one byte.
// - Fixed frame: preamble, sync, address, message, CRC.
// - Variable length comes from first FIFO byte.
// - Variable payload holds at least one byte, the length byte.
// - CRC excludes the variable length byte.
// - Sync size, tolerance, 32-bit value in four bytes.
// - Fill method and fill control steer receive filling.
// - Receive fills after sync or on fill control.
// - Transmit complete eight bits after last load, seven in packet mode.
// - Full FIFO: overrun after shift register fills.
// - Start-select zero: send when threshold reached.
module fpd_handler (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire bit_clock,
  input wire rx_data_in,
  output reg tx_data_out,
  output reg interrupt_line_a,
  output reg interrupt_line_b,
  output reg bit_sync_enable
);
  // --------------------------------------------------------------------------
  // Registers and storage
  // --------------------------------------------------------------------------
  reg [7:0] data_path_mode_q, fifo_config_q, interrupt_source_select_q, fill_and_start_control_q;
  reg [7:0] sync_match_config_q, sync_pattern_byte3_q, sync_pattern_byte2_q, sync_pattern_byte1_q;
  reg [7:0] sync_pattern_byte0_q, packet_control_reg_q, payload_length_reg_q;
  reg [1:0] chip_mode_q;
  reg [7:0] fifo_mem [0:63];
  reg [5:0] wr_ptr_q, rd_ptr_q;
  reg [6:0] count_q;
  reg queue_overrun_flag_q, transmit_complete_q, sync_seen_q, filling_q;
  reg [2:0] bclk_sync_q;
  reg rx_s1_q, rx_s2_q;
  reg [7:0] shift_register_q;
  reg [3:0] bit_cnt_q;
  reg sr_busy_q, tx_started_q, prev_tx_q;
  reg [31:0] sync_hist_q;
  reg [1:0] ph_q;
  reg [6:0] ph_cnt_q;
  reg [15:0] crc_q;
  reg [7:0] wait_q;
  // --------------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------------
  function [6:0] depth_of;
    input [1:0] sel;
    begin
      depth_of = {sel, 4'h0} + 7'd16;
    end
  endfunction
  function [15:0] crc_step;
    input [15:0] c;
    input b;
    begin
      crc_step = {c[14:0], 1'b0} ^ ((c[15] ^ b) ? `FPD_CRC_POLY : 16'h0000);
    end
  endfunction
  function [5:0] ones32;
    input [31:0] v;
    integer i;
    begin
      ones32 = 6'd0;
      for (i = 0; i < 32; i = i + 1) begin
        ones32 = ones32 + {5'd0, v[i]};
      end
    end
  endfunction
  wire buffered_mode = data_path_mode_q[`FPD_B_MODE_HIGH:`FPD_B_MODE_LOW] == 2'b01;
  wire packet_mode = data_path_mode_q[`FPD_B_MODE_HIGH];
  wire [6:0] depth = depth_of(fifo_config_q[7:`FPD_B_DEPTH_LO]);
  wire [6:0] threshold = {1'b0, fifo_config_q[`FPD_B_THR_HI:0]};
  wire queue_empty_event = count_q == 7'd0;
  wire queue_full_event = count_q == depth;
  wire in_tx = chip_mode_q == `FPD_CHIP_TX;
  wire in_rx = chip_mode_q == `FPD_CHIP_RX;
  wire [31:0] pattern_value = {sync_pattern_byte3_q, sync_pattern_byte2_q,
                               sync_pattern_byte1_q, sync_pattern_byte0_q};
  wire [1:0] pattern_size = sync_match_config_q[`FPD_B_SYNC_SIZE_LO+1:`FPD_B_SYNC_SIZE_LO];
  wire [1:0] pattern_error_tolerance = sync_match_config_q[`FPD_B_SYNC_TOL_LO+1:`FPD_B_SYNC_TOL_LO];
  wire pattern_detect_enable = sync_match_config_q[`FPD_B_SYNC_EN] | packet_mode;
  wire fill_method_select = fill_and_start_control_q[`FPD_B_FILL_METHOD];
  wire fill_control = fill_and_start_control_q[`FPD_B_FILL_CTRL];
  wire tx_start_select = fill_and_start_control_q[`FPD_B_START_SEL];
  // --------------------------------------------------------------------------
  // APB slave
  // --------------------------------------------------------------------------
  wire wr_en = psel & penable & pwrite;
  wire rd_en = psel & penable & ~pwrite;
  wire fifo_acc = paddr == `FPD_A_FIFO_DATA;
  reg known;
  always @* begin
    known = 1'b1;
    prdata = 32'h0;
    case (paddr)
      `FPD_A_DATA_PATH_MODE: prdata = {24'h0, data_path_mode_q};
      `FPD_A_FIFO_CONFIG: prdata = {24'h0, fifo_config_q};
      `FPD_A_IRQ_SELECT: prdata = {24'h0, interrupt_source_select_q};
      `FPD_A_FILL_START: prdata = {24'h0, fill_and_start_control_q};
      `FPD_A_SYNC_CONFIG: prdata = {24'h0, sync_match_config_q};
      `FPD_A_SYNC_B3: prdata = {24'h0, sync_pattern_byte3_q};
      `FPD_A_SYNC_B2: prdata = {24'h0, sync_pattern_byte2_q};
      `FPD_A_SYNC_B1: prdata = {24'h0, sync_pattern_byte1_q};
      `FPD_A_SYNC_B0: prdata = {24'h0, sync_pattern_byte0_q};
      `FPD_A_PACKET_CTRL: prdata = {24'h0, packet_control_reg_q};
      `FPD_A_PAYLOAD_LEN: prdata = {24'h0, payload_length_reg_q};
      `FPD_A_FIFO_DATA: prdata = {24'h0, fifo_mem[rd_ptr_q]};
      `FPD_A_STATUS: prdata = {18'h0, ph_q, transmit_complete_q, queue_overrun_flag_q,
                               queue_full_event, queue_empty_event, count_q, sync_seen_q};
      `FPD_A_CHIP_MODE: prdata = {30'h0, chip_mode_q};
      default: known = 1'b0;
    endcase
  end
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~known;
  // --------------------------------------------------------------------------
  // Bit clock edge detection and receive sampling
  // --------------------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bclk_sync_q <= 3'b000;
      rx_s1_q <= 1'b0;
      rx_s2_q <= 1'b0;
    end else begin
      bclk_sync_q <= {bclk_sync_q[1:0], bit_clock};
      rx_s1_q <= rx_data_in;
      rx_s2_q <= rx_s1_q;
    end
  end
  wire bit_tick = bclk_sync_q[1] & ~bclk_sync_q[2];
  // --------------------------------------------------------------------------
  // Datapath
  // --------------------------------------------------------------------------
  localparam PH_PRE = 2'd0, PH_SYNC = 2'd1, PH_PAY = 2'd2, PH_CRC = 2'd3;
  wire host_push = wr_en & fifo_acc & ~queue_full_event & (in_tx | ~in_rx | ~packet_mode);
  wire host_pop = rd_en & fifo_acc & ~queue_empty_event;
  wire [5:0] sync_bits = {pattern_size, 3'b000} + 6'd8;
  wire [31:0] sync_mask = ~(32'hffff_ffff << sync_bits);
  wire sync_match = pattern_detect_enable &
                    ({3'b0, ones32((sync_hist_q ^ pattern_value) & sync_mask)} <= {7'b0, pattern_error_tolerance});
  wire tx_go = tx_start_select ? ~queue_empty_event : (count_q >= threshold);
  wire [6:0] pay_len = packet_control_reg_q[`FPD_B_LEN_FORMAT] ? fifo_mem[rd_ptr_q][6:0]
                                                              : payload_length_reg_q[6:0];
  reg tx_load, rx_push, crc_done;
  reg [7:0] tx_byte;
  always @* begin
    tx_load = 1'b0;
    tx_byte = fifo_mem[rd_ptr_q];
    if (packet_mode && ph_q == PH_PRE) begin
      tx_byte = `FPD_PREAMBLE_BYTE;
    end else if (packet_mode && ph_q == PH_SYNC) begin
      tx_byte = pattern_value[{ph_cnt_q[1:0], 3'b111} -: 8];
    end else if (packet_mode && ph_q == PH_CRC) begin
      tx_byte = ph_cnt_q[0] ? crc_q[7:0] : crc_q[15:8];
    end
    if (in_tx && bit_tick && !sr_busy_q && tx_started_q) begin
      tx_load = (packet_mode && ph_q != PH_PAY) || !queue_empty_event;
    end
    rx_push = in_rx && bit_tick && bit_cnt_q == 4'd7 && filling_q;
    crc_done = 1'b0;
  end
  wire pop_for_tx = tx_load & (~packet_mode | ph_q == PH_PAY);
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      data_path_mode_q <= `FPD_RST_BYTE;
      fifo_config_q <= `FPD_RST_THRESHOLD;
      interrupt_source_select_q <= `FPD_RST_BYTE;
      fill_and_start_control_q <= `FPD_RST_BYTE;
      sync_match_config_q <= `FPD_RST_BYTE;
      sync_pattern_byte3_q <= `FPD_RST_BYTE;
      sync_pattern_byte2_q <= `FPD_RST_BYTE;
      sync_pattern_byte1_q <= `FPD_RST_BYTE;
      sync_pattern_byte0_q <= `FPD_RST_BYTE;
      packet_control_reg_q <= `FPD_RST_BYTE;
      payload_length_reg_q <= `FPD_RST_BYTE;
      chip_mode_q <= `FPD_CHIP_STANDBY;
      wr_ptr_q <= 6'd0;
      rd_ptr_q <= 6'd0;
      count_q <= 7'd0;
      queue_overrun_flag_q <= 1'b0;
      transmit_complete_q <= 1'b0;
      sync_seen_q <= 1'b0;
      filling_q <= 1'b0;
      shift_register_q <= 8'h00;
      bit_cnt_q <= 4'd0;
      sr_busy_q <= 1'b0;
      tx_started_q <= 1'b0;
      prev_tx_q <= 1'b0;
      sync_hist_q <= 32'h0;
      ph_q <= PH_PRE;
      ph_cnt_q <= 7'd0;
      crc_q <= `FPD_CRC_INIT;
      tx_data_out <= 1'b1;
      wait_q <= 8'h00;
    end else begin
      if (wr_en) begin
        case (paddr)
          `FPD_A_DATA_PATH_MODE: data_path_mode_q <= pwdata[7:0];
          `FPD_A_FIFO_CONFIG: fifo_config_q <= pwdata[7:0];
          `FPD_A_IRQ_SELECT: interrupt_source_select_q <= pwdata[7:0];
          `FPD_A_FILL_START: fill_and_start_control_q <= pwdata[7:0];
          `FPD_A_SYNC_CONFIG: sync_match_config_q <= pwdata[7:0];
          `FPD_A_SYNC_B3: sync_pattern_byte3_q <= pwdata[7:0];
          `FPD_A_SYNC_B2: sync_pattern_byte2_q <= pwdata[7:0];
          `FPD_A_SYNC_B1: sync_pattern_byte1_q <= pwdata[7:0];
          `FPD_A_SYNC_B0: sync_pattern_byte0_q <= pwdata[7:0];
          `FPD_A_PACKET_CTRL: packet_control_reg_q <= pwdata[7:0];
          `FPD_A_PAYLOAD_LEN: payload_length_reg_q <= pwdata[7:0];
          `FPD_A_CHIP_MODE: chip_mode_q <= pwdata[1:0];
          `FPD_A_STATUS: begin
            // Writing one clears the sticky flags; a new event in the same cycle wins.
            if (pwdata[9]) queue_overrun_flag_q <= 1'b0;
            if (pwdata[10]) transmit_complete_q <= 1'b0;
          end
          default: wait_q <= wait_q;
        endcase
      end
      // FIFO pointers; a bit-clock push and a host pop may coincide.
      if (host_push) begin
        fifo_mem[wr_ptr_q] <= pwdata[7:0];
      end else if (rx_push && !queue_full_event) begin
        fifo_mem[wr_ptr_q] <= {shift_register_q[6:0], rx_s2_q};
      end
      wr_ptr_q <= ((host_push || (rx_push && !queue_full_event)) ?
                  ((wr_ptr_q + 6'd1) == depth[5:0] ? 6'd0 : wr_ptr_q + 6'd1) : wr_ptr_q);
      rd_ptr_q <= (host_pop || pop_for_tx) ?
                  ((rd_ptr_q + 6'd1) == depth[5:0] ? 6'd0 : rd_ptr_q + 6'd1) : rd_ptr_q;
      count_q <= count_q + {6'd0, host_push | (rx_push & ~queue_full_event)}
                 - {6'd0, host_pop | pop_for_tx};
      if (rx_push && queue_full_event) begin
        queue_overrun_flag_q <= 1'b1;
      end
      prev_tx_q <= in_tx;
      // Transmit side.
      if (!in_tx) begin
        tx_data_out <= 1'b1;
        tx_started_q <= 1'b0;
        sr_busy_q <= 1'b0;
        ph_q <= PH_PRE;
        ph_cnt_q <= 7'd0;
      end else begin
        if (!tx_started_q && tx_go) tx_started_q <= 1'b1;
        if (!prev_tx_q) transmit_complete_q <= 1'b0;
        if (tx_load) begin
          // The first bit leaves on the loading tick, so bytes follow each other with no gap.
          tx_data_out <= tx_byte[7];
          shift_register_q <= {tx_byte[6:0], 1'b0};
          bit_cnt_q <= 4'd1;
          sr_busy_q <= 1'b1;
          if (packet_mode && ph_q == PH_PAY && !(packet_control_reg_q[`FPD_B_LEN_FORMAT] && ph_cnt_q == 7'd0))
            crc_q <= crc_step(crc_q, tx_byte[7]);
          ph_cnt_q <= ph_cnt_q + 7'd1;
          if (packet_mode) begin
            case (ph_q)
              PH_PRE: if (ph_cnt_q + 7'd1 >= {4'd0, `FPD_RST_PREAMBLE_BYTES}) begin
                ph_q <= PH_SYNC;
                ph_cnt_q <= {5'd0, pattern_size};
              end
              PH_SYNC: if (ph_cnt_q[1:0] == 2'd0) begin
                ph_q <= PH_PAY;
                ph_cnt_q <= 7'd0;
                crc_q <= `FPD_CRC_INIT;
              end else begin
                ph_cnt_q <= ph_cnt_q - 7'd1;
              end
              PH_PAY: if (ph_cnt_q + 7'd1 >= pay_len + {6'd0, packet_control_reg_q[`FPD_B_LEN_FORMAT]}) begin
                ph_q <= packet_control_reg_q[`FPD_B_CRC_EN] ? PH_CRC : PH_PRE;
                ph_cnt_q <= 7'd0;
              end
              PH_CRC: if (ph_cnt_q[0]) begin
                ph_q <= PH_PRE;
                ph_cnt_q <= 7'd0;
              end
              default: ph_q <= PH_PRE;
            endcase
          end
        end else if (bit_tick && sr_busy_q) begin
          tx_data_out <= shift_register_q[7];
          shift_register_q <= {shift_register_q[6:0], 1'b0};
          if (packet_mode && ph_q == PH_PAY && !(packet_control_reg_q[`FPD_B_LEN_FORMAT] && ph_cnt_q == 7'd1))
            crc_q <= crc_step(crc_q, shift_register_q[7]);
          bit_cnt_q <= bit_cnt_q + 4'd1;
          if (bit_cnt_q == `FPD_BITS_PER_BYTE - 4'd1) begin
            sr_busy_q <= 1'b0;
            if (queue_empty_event && packet_mode && ph_q == PH_PRE)
              transmit_complete_q <= 1'b1;
          end
        end else if (bit_tick && tx_started_q && !packet_mode) begin
          // The last bit has now been on the line for a full bit period.
          transmit_complete_q <= 1'b1;
        end
      end
      // Receive side; leaving receive discards the partial byte and stops filling.
      if (!in_rx) begin
        if (!in_tx) bit_cnt_q <= 4'd0;
        sync_seen_q <= in_tx ? sync_seen_q : 1'b0;
        filling_q <= 1'b0;
      end else if (bit_tick) begin
        shift_register_q <= {shift_register_q[6:0], rx_s2_q};
        sync_hist_q <= {sync_hist_q[30:0], rx_s2_q};
        bit_cnt_q <= (bit_cnt_q == 4'd7) ? 4'd0 : bit_cnt_q + 4'd1;
        if (!filling_q && !fill_method_select && sync_match) begin
          sync_seen_q <= 1'b1;
          filling_q <= 1'b1;
          bit_cnt_q <= 4'd1;
        end
        if (fill_method_select) filling_q <= fill_control;
      end
    end
  end
  // --------------------------------------------------------------------------
  // Interrupt line mapping
  // --------------------------------------------------------------------------
  wire [1:0] rx_line0_select = interrupt_source_select_q[`FPD_B_RX0_LO+1:`FPD_B_RX0_LO];
  wire [1:0] rx_line1_select = interrupt_source_select_q[`FPD_B_RX1_LO+1:`FPD_B_RX1_LO];
  wire tx_line1_select = interrupt_source_select_q[`FPD_B_LINE1_TX];
  wire thr_hit = (count_q >= threshold) & (sync_seen_q | fill_method_select);
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      interrupt_line_a <= 1'b0;
      interrupt_line_b <= 1'b0;
      bit_sync_enable <= 1'b0;
    end else begin
      bit_sync_enable <= buffered_mode | packet_mode;
      if (in_tx) begin
        interrupt_line_a <= tx_start_select & queue_empty_event;
        interrupt_line_b <= tx_line1_select ? transmit_complete_q : queue_full_event;
      end else begin
        case (rx_line0_select)
          `FPD_SEL_RX0_EMPTY: interrupt_line_a <= queue_empty_event;
          `FPD_SEL_RX0_SYNC: interrupt_line_a <= in_rx & sync_seen_q;
          default: interrupt_line_a <= 1'b0;
        endcase
        case (rx_line1_select)
          `FPD_SEL_RX1_FULL: interrupt_line_b <= queue_full_event;
          `FPD_SEL_RX1_THR: interrupt_line_b <= thr_hit;
          default: interrupt_line_b <= 1'b0;
        endcase
      end
    end
  end
endmodule // fpd_handler

/* File: verif/fpd_handler_props.sv */
// Concurrent checks on the ports of the FIFO packet data handler.
`timescale 1ns/1ps
`include "fpd_regs.vh"
module fpd_handler_props (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic tx_data_out,
  input wire logic interrupt_line_a,
  input wire logic interrupt_line_b,
  input wire logic bit_sync_enable
);
  // ----------------------------------------------------------------------------
  // Shadow copies of the mode, chip mode and interrupt select registers
  // ----------------------------------------------------------------------------
  logic [1:0] mode_q;
  logic [1:0] chip_q;
  logic [7:0] irq_q;
  wire wr_w = psel && penable && pwrite && pready;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q <= 2'h0;
      chip_q <= 2'h0;
      irq_q <= 8'h00;
    end else if (wr_w) begin
      if (paddr == `FPD_A_DATA_PATH_MODE) mode_q <= pwdata[1:0];
      if (paddr == `FPD_A_CHIP_MODE) chip_q <= pwdata[1:0];
      if (paddr == `FPD_A_IRQ_SELECT) irq_q <= pwdata[7:0];
    end
  end
  // ----------------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  ready_zero_wait_a: assert property (psel && penable |-> pready)
    else $error("access phase without ready");
  err_unmapped_a: assert property (psel && penable && paddr > `FPD_A_CHIP_MODE |-> pslverr)
    else $error("unmapped access without error");
  err_mapped_a: assert property (psel && penable && paddr <= `FPD_A_CHIP_MODE && paddr[1:0] == 2'h0 |-> !pslverr)
    else $error("mapped access flagged as error");
  sync_enable_a: assert property ($stable(mode_q)[*3] |-> bit_sync_enable == (mode_q != 2'h0))
    else $error("bit sync enable does not follow data mode");
  tx_bit_hold_a: assert property ($changed(tx_data_out) |=> $stable(tx_data_out)[*8])
    else $error("transmit bit shorter than a bit period");
  tx_idle_a: assert property ((chip_q == `FPD_CHIP_STANDBY)[*4] |-> tx_data_out)
    else $error("transmit line active in standby");
  line_a_quiet_a: assert property ((chip_q != `FPD_CHIP_TX && !mode_q[1] && irq_q[5:4] == 2'h0)[*2] |-> !interrupt_line_a)
    else $error("line a raised with no source selected");
  line_b_quiet_a: assert property ((chip_q != `FPD_CHIP_TX && !mode_q[1] && irq_q[3:2] == 2'h0)[*2] |-> !interrupt_line_b)
    else $error("line b raised with no source selected");
  tx_moving_c: cover property (chip_q == `FPD_CHIP_TX && $changed(tx_data_out));
  line_b_rise_c: cover property ($rose(interrupt_line_b));
  line_a_rise_c: cover property ($rose(interrupt_line_a));
endmodule // fpd_handler_props

bind fpd_handler fpd_handler_props i_fpd_handler_props (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
  .tx_data_out(tx_data_out), .interrupt_line_a(interrupt_line_a), .interrupt_line_b(interrupt_line_b),
  .bit_sync_enable(bit_sync_enable));

/* File: verif/fpd_handler_tb.sv */
// Self-checking bench for the FIFO packet data handler over APB with a modem model.
`timescale 1ns/1ps
`include "fpd_regs.vh"
module fpd_handler_tb;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic link_run = 1'b0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic bit_clock;
  logic rx_data_in;
  logic tx_data_out;
  logic interrupt_line_a;
  logic interrupt_line_b;
  logic bit_sync_enable;
  logic [31:0] rdata;
  logic rerr;
  integer bad_count = 0;
  integer cmp_count = 0;

  always #2.5 pclk = ~pclk;

  fpd_handler i_fpd_handler (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .bit_clock(bit_clock),
    .rx_data_in(rx_data_in), .tx_data_out(tx_data_out), .interrupt_line_a(interrupt_line_a),
    .interrupt_line_b(interrupt_line_b), .bit_sync_enable(bit_sync_enable));
  fpd_modem_model i_fpd_modem_model (.run(link_run), .bit_clock(bit_clock), .rx_data_in(rx_data_in),
    .tx_data_out(tx_data_out));

  // ----------------------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------------------
  task automatic apb_xfer(input logic wr, input logic [11:0] a, input logic [31:0] d);
    integer k;
    begin
      k = 0;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1 && k < 50) begin
        @(posedge pclk);
        k = k + 1;
      end
      if (k >= 50) bad_count = bad_count + 1;
      rdata = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
    end
  endtask

  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    begin
      cmp_count = cmp_count + 1;
      if (got !== exp) begin
        bad_count = bad_count + 1;
        $display("wrong value %s expected %h seen %h", name, exp, got);
      end
    end
  endtask

  task automatic wait_line(input logic sel_b, input integer lim);
    integer k;
    begin
      k = 0;
      while ((sel_b ? interrupt_line_b : interrupt_line_a) !== 1'b1 && k < lim) begin
        @(posedge pclk);
        k = k + 1;
      end
    end
  endtask

  task automatic print_verdict;
    begin
      $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0)
        $display("All checks passed");
      else
        $display("Checks failed");
      $finish;
    end
  endtask

  // ----------------------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------------------
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb_xfer(1'b0, `FPD_A_FIFO_CONFIG, 32'h0);
    check("fifo_config reset", {24'h0, `FPD_RST_THRESHOLD}, rdata);
    apb_xfer(1'b1, `FPD_A_SYNC_B3, 32'h2d);
    apb_xfer(1'b0, `FPD_A_SYNC_B3, 32'h0);
    check("sync_pattern_byte3", 32'h2d, rdata);
    apb_xfer(1'b0, 12'h100, 32'h0);
    check("unmapped error", 32'h1, {31'h0, rerr});
    $display("test registers done");
    apb_xfer(1'b1, `FPD_A_DATA_PATH_MODE, 32'h01);
    apb_xfer(1'b1, `FPD_A_IRQ_SELECT, 32'h01);
    apb_xfer(1'b1, `FPD_A_FILL_START, 32'h10);
    apb_xfer(1'b1, `FPD_A_CHIP_MODE, {30'h0, `FPD_CHIP_TX});
    link_run <= 1'b1;
    repeat (100) @(posedge pclk);
    apb_xfer(1'b1, `FPD_A_FIFO_DATA, 32'h5a);
    apb_xfer(1'b1, `FPD_A_FIFO_DATA, 32'h0f);
    wait_line(1'b1, 2000);
    check("line b transmit complete", 32'h1, {31'h0, interrupt_line_b});
    check("bits sent before complete", 32'd16, i_fpd_modem_model.tx_bits);
    check("sent word", 32'h5a0f, {16'h0, i_fpd_modem_model.tx_word});
    repeat (25) @(posedge pclk);
    apb_xfer(1'b1, `FPD_A_CHIP_MODE, {30'h0, `FPD_CHIP_STANDBY});
    link_run <= 1'b0;
    $display("test transmit done");
    apb_xfer(1'b1, `FPD_A_IRQ_SELECT, 32'h2c);
    @(posedge pclk);
    check("line a empty in standby", 32'h1, {31'h0, interrupt_line_a});
    apb_xfer(1'b1, `FPD_A_FILL_START, 32'h00);
    apb_xfer(1'b1, `FPD_A_SYNC_CONFIG, 32'h98);
    apb_xfer(1'b1, `FPD_A_SYNC_B2, 32'hd4);
    apb_xfer(1'b1, `FPD_A_SYNC_B1, 32'h69);
    apb_xfer(1'b1, `FPD_A_SYNC_B0, 32'h1e);
    apb_xfer(1'b1, `FPD_A_FIFO_CONFIG, 32'h02);
    apb_xfer(1'b1, `FPD_A_CHIP_MODE, {30'h0, `FPD_CHIP_RX});
    link_run <= 1'b1;
    repeat (100) @(posedge pclk);
    check("no threshold before sync", 32'h0, {31'h0, interrupt_line_b});
    i_fpd_modem_model.rx_q = '{8'h2d, 8'hd4, 8'h69, 8'h1e, 8'h3c, 8'hc3};
    wait_line(1'b1, 3000);
    check("line b threshold", 32'h1, {31'h0, interrupt_line_b});
    apb_xfer(1'b1, `FPD_A_CHIP_MODE, {30'h0, `FPD_CHIP_STANDBY});
    link_run <= 1'b0;
    check("line a with data held", 32'h0, {31'h0, interrupt_line_a});
    apb_xfer(1'b0, `FPD_A_FIFO_DATA, 32'h0);
    check("first byte", 32'h3c, rdata);
    apb_xfer(1'b0, `FPD_A_FIFO_DATA, 32'h0);
    check("second byte", 32'hc3, rdata);
    repeat (2) @(posedge pclk);
    check("line a empty after reads", 32'h1, {31'h0, interrupt_line_a});
    $display("test receive done");
    print_verdict;
  end

  initial begin
    repeat (20000) @(posedge pclk);
    bad_count = bad_count + 1;
    print_verdict;
  end
endmodule // fpd_handler_tb

/* File: verif/fpd_modem_model.sv */
// Bit-serial modem model: makes the bit clock, sends receive bytes and collects transmitted bits.
`timescale 1ns/1ps
module fpd_modem_model (
  input wire logic run,
  output logic bit_clock,
  output logic rx_data_in,
  input wire logic tx_data_out
);
  logic [7:0] rx_q[$];
  logic [7:0] cur;
  integer left = 0;
  logic [15:0] tx_word = 16'h0000;
  integer tx_bits = 0;
  initial begin
    bit_clock = 1'b0;
    rx_data_in = 1'b0;
  end
  // The bit clock halts low while run is low.
  always begin
    #62.5;
    if (run || bit_clock) bit_clock = ~bit_clock;
  end
  // Receive bits change on the falling edge; idle bits toggle so no stale level is seen.
  always @(negedge bit_clock) begin
    if (left == 0 && rx_q.size() > 0) begin
      cur = rx_q.pop_front();
      left = 8;
    end
    if (left > 0) begin
      rx_data_in <= cur[7];
      cur = {cur[6:0], 1'b0};
      left = left - 1;
    end else begin
      rx_data_in <= ~rx_data_in;
    end
    if ((tx_bits > 0 || tx_data_out === 1'b0) && tx_bits < 16) begin
      tx_word = {tx_word[14:0], tx_data_out};
      tx_bits = tx_bits + 1;
    end
  end
endmodule // fpd_modem_model
